// File: dv/ocs_ctrl_model.sv
/*
 * Behavioural model of the external controller at the select pin.
 * Assumes the bench steers it by enable and level just after a
 * rising edge of sys_clk.
 */
module ocs_ctrl_model (
    input  wire logic sys_clk,
    input  wire logic drive_en,
    input  wire logic level,
    output logic      cal_select
);
    timeunit 1ns;
    timeprecision 1ps;

    ////////////////////////////////////////////////////////////////////
    // One select pin only, changed once per edge, never paired
    logic level_r;

    // Level launched after the edge, held until the next one
    always_ff @(posedge sys_clk) begin
        level_r <= level;
    end

    // Released pin falls to the pull-down level
    assign cal_select = drive_en ? level_r : 1'b0;
endmodule

// File: dv/ocs_top_tb.sv
/*
 * Self-checking bench for the offset calibration sequencer.
 * Assumes shortened delays: POR 20, settle 10, calibrate 80.
 */
module ocs_top_tb;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int POR_D = 20;
    localparam int SET_D = 10;
    localparam int CAL_D = 80;
    // Packed control levels {out_hiz, low_power, in_isolate, divider_on}
    localparam logic [7:0] C_NORM = 8'h00;
    localparam logic [7:0] C_LOWP = 8'h0C;
    localparam logic [7:0] C_CAL  = 8'h0B;

    logic                       sys_clk;
    logic                       rst;
    logic                       supply_ok;
    logic                       offset_cmp;
    logic                       mem_upset;
    logic                       sel_en;
    logic                       sel_lvl;
    logic                       cal_select;
    logic                       cal_busy;
    ocs_pkg::ocs_ctrl_t         ctrl;
    ocs_pkg::ocs_ctrl_t         ctrl_ns;
    logic [ocs_pkg::TRIM_W-1:0] trim;
    int                         err_total;
    int                         comparisons;
    int                         n;

    ////////////////////////////////////////////////////////////////////
    // Far side, design with select pin, and pin-less variant
    ocs_ctrl_model ocs_ctrl_model_i (
        .sys_clk    (sys_clk),
        .drive_en   (sel_en),
        .level      (sel_lvl),
        .cal_select (cal_select)
    );

    ocs_top #(.HAS_SELECT(1'b1), .POR_DELAY(POR_D),
              .SETTLE_DELAY(SET_D), .CAL_TIME(CAL_D)) ocs_top_i (
        .sys_clk    (sys_clk),
        .rst        (rst),
        .cal_select (cal_select),
        .supply_ok  (supply_ok),
        .offset_cmp (offset_cmp),
        .mem_upset  (mem_upset),
        .ctrl       (ctrl),
        .trim       (trim),
        .cal_busy   (cal_busy)
    );

    ocs_top #(.HAS_SELECT(1'b0), .POR_DELAY(POR_D),
              .SETTLE_DELAY(SET_D), .CAL_TIME(CAL_D)) ocs_top_nosel_i (
        .sys_clk    (sys_clk),
        .rst        (rst),
        .cal_select (cal_select),
        .supply_ok  (supply_ok),
        .offset_cmp (offset_cmp),
        .mem_upset  (mem_upset),
        .ctrl       (ctrl_ns),
        .trim       (),
        .cal_busy   ()
    );

    ////////////////////////////////////////////////////////////////////
    // Clock, 100 MHz
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // Value compare
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Cycle count compare against a window
    task automatic check_rng(input int c, input int lo, input int hi);
        comparisons++;
        if (c < lo || c > hi) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h..%h", $time, c, lo,
                     hi);
        end
    endtask

    // Bounded wait for the busy flag to reach a level
    task automatic wait_lvl(input logic lvl, output int c);
        c = 0;
        while (cal_busy !== lvl && c < 400) begin
            @(negedge sys_clk);
            c++;
        end
    endtask

    // Busy window of settle plus calibrate, then normal drive
    task automatic finish_cal(input logic [7:0] exp_trim);
        wait_lvl(1'b0, n);
        check_rng(n, SET_D + CAL_D - 2, SET_D + CAL_D + 1);
        @(negedge sys_clk);
        check({4'h0, ctrl}, C_NORM);
        check(trim, exp_trim);
    endtask

    ////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic s_power_up;
        @(negedge sys_clk);
        check({4'h0, ctrl}, C_LOWP);
        check(trim, 8'h80);
        @(posedge sys_clk);
        supply_ok <= 1'b1;
        wait_lvl(1'b1, n);
        check_rng(n, POR_D, POR_D + 4);
        @(negedge sys_clk);
        check({4'h0, ctrl}, C_CAL);
        check({4'h0, ctrl_ns}, C_CAL);
        finish_cal(8'hFF);
    endtask

    task automatic s_select;
        @(posedge sys_clk);
        sel_en  <= 1'b1;
        sel_lvl <= 1'b1;
        repeat (5) @(negedge sys_clk);
        check({4'h0, ctrl}, C_LOWP);
        check({4'h0, ctrl_ns}, C_NORM);
        @(posedge sys_clk);
        offset_cmp <= 1'b0;
        sel_lvl    <= 1'b0;
        wait_lvl(1'b1, n);
        check_rng(n, 1, 5);
        finish_cal(8'h00);
    endtask

    task automatic s_abort;
        @(posedge sys_clk);
        offset_cmp <= 1'b1;
        sel_lvl    <= 1'b1;
        repeat (5) @(posedge sys_clk);
        sel_lvl <= 1'b0;
        wait_lvl(1'b1, n);
        repeat (30) @(posedge sys_clk);
        sel_lvl <= 1'b1;
        repeat (5) @(negedge sys_clk);
        check({4'h0, ctrl}, C_LOWP);
        check(trim, 8'h00);
        @(posedge sys_clk);
        sel_en <= 1'b0;
        wait_lvl(1'b1, n);
        check_rng(n, 1, 6);
        finish_cal(8'hFF);
    endtask

    task automatic s_brownout;
        @(posedge sys_clk);
        supply_ok <= 1'b0;
        repeat (5) @(negedge sys_clk);
        check({4'h0, ctrl}, C_LOWP);
        check({4'h0, ctrl_ns}, C_LOWP);
        @(posedge sys_clk);
        supply_ok <= 1'b1;
        wait_lvl(1'b1, n);
        check_rng(n, POR_D, POR_D + 4);
        finish_cal(8'hFF);
    endtask

    task automatic s_parity;
        @(posedge sys_clk);
        mem_upset <= 1'b1;
        @(posedge sys_clk);
        mem_upset <= 1'b0;
        repeat (3) @(negedge sys_clk);
        check({4'h0, ctrl}, C_LOWP);
        wait_lvl(1'b1, n);
        check_rng(n, POR_D - 3, POR_D + 4);
        finish_cal(8'hFF);
    endtask

    // Select held high across supply recovery stays in low power
    task automatic s_sel_por;
        @(posedge sys_clk);
        sel_en    <= 1'b1;
        sel_lvl   <= 1'b1;
        supply_ok <= 1'b0;
        repeat (5) @(posedge sys_clk);
        supply_ok <= 1'b1;
        repeat (POR_D + 10) @(negedge sys_clk);
        check({4'h0, ctrl}, C_LOWP);
        check({4'h0, ctrl_ns}, C_CAL);
        @(posedge sys_clk);
        sel_lvl <= 1'b0;
        wait_lvl(1'b1, n);
        check_rng(n, 1, 5);
        finish_cal(8'hFF);
    endtask

    ////////////////////////////////////////////////////////////////////
    // Verdict
    task automatic test_done;
        $display("errors=%0d comparisons=%0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Watchdog
    initial begin
        repeat (3000) @(posedge sys_clk);
        err_total++;
        test_done();
    end

    // Main sequence
    initial begin
        err_total   = 0;
        comparisons = 0;
        rst         = 1'b1;
        supply_ok   = 1'b0;
        offset_cmp  = 1'b1;
        mem_upset   = 1'b0;
        sel_en      = 1'b0;
        sel_lvl     = 1'b0;
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        s_power_up();
        s_select();
        s_abort();
        s_brownout();
        s_parity();
        s_sel_por();
        test_done();
    end
endmodule

// File: rtl/ocs_cal_mem.sv
/*
 * Calibration constant memory with continuous parity checking.
 * Assumes the write strobe comes from the sequencer on sys_clk.
 */
module ocs_cal_mem #(
    parameter int unsigned W = ocs_pkg::TRIM_W
) (
    input  wire logic         sys_clk,
    input  wire logic         rst,
    input  wire logic         wr_en,
    input  wire logic [W-1:0] wr_data,
    input  wire logic         upset,
    output logic     [W-1:0]  trim,
    output logic              par_err
);

    typedef struct packed {
        logic [W-1:0] trim;
        logic         par;
    } ocs_cm_state_t;

    ocs_cm_state_t st_r;
    ocs_cm_state_t st_nxt;

    // Store constants with even parity; upset flips the stored parity
    always_comb begin
        st_nxt = st_r;
        if (wr_en) begin
            st_nxt.trim = wr_data;
            st_nxt.par  = ^wr_data;
        end else if (upset) begin
            st_nxt.par  = ~st_r.par;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st_r <= '{trim: ocs_pkg::TRIM_RST, par: 1'b1};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign trim    = st_r.trim;
    // Parity checked every cycle
    assign par_err = (^st_r.trim) != st_r.par;

endmodule

// File: rtl/ocs_pkg.sv
/*
 * Package for the offset calibration sequencer: timing constants,
 * sequencer states and the control and status carriers.
 * Assumes a 100 MHz system clock.
 */
package ocs_pkg;

    // Clock rate
    localparam int unsigned CLK_HZ         = 100_000_000;

    // Typical turn-on after a select-pin calibration, in microseconds
    localparam int unsigned PIN_TURN_ON_US = 5_000;
    // Typical power-on turn-on time, in microseconds
    localparam int unsigned POWER_ON_TURN_ON_TIME_US = 200_000;
    // Portion of the pin turn-on spent settling, in microseconds
    localparam int unsigned SETTLE_US      = 1_000;

    // Derived cycle counts (longest times round down)
    localparam int unsigned PIN_TURN_ON_CYC =
        PIN_TURN_ON_US * (CLK_HZ / 1_000_000);
    localparam int unsigned SETTLE_CYC     =
        SETTLE_US * (CLK_HZ / 1_000_000);
    localparam int unsigned CAL_CYC        = PIN_TURN_ON_CYC - SETTLE_CYC;
    localparam int unsigned POWER_ON_TURN_ON_TIME_CYC =
        POWER_ON_TURN_ON_TIME_US * (CLK_HZ / 1_000_000);
    // Supply-recovery delay before the settle and calibrate steps
    localparam int unsigned POR_DELAY_CYC  =
        POWER_ON_TURN_ON_TIME_CYC - PIN_TURN_ON_CYC;

    // Width of the calibration trim word and of the timer
    localparam int unsigned TRIM_W         = 8;
    localparam int unsigned TMR_W          = 32;

    // Reset values
    localparam logic [TRIM_W-1:0] TRIM_RST = 8'h80;
    localparam logic [TMR_W-1:0]  TMR_RST  = 32'h0000_0000;

    // Sequencer states
    typedef enum logic [2:0] {
        OCS_LOW_POWER,
        OCS_POR_WAIT,
        OCS_SETTLE,
        OCS_CALIBRATE,
        OCS_NORMAL
    } ocs_state_t;

    // Analog control outputs
    typedef struct packed {
        logic out_hiz;       // Output driver high impedance
        logic low_power;     // Amplifier biased down
        logic in_isolate;    // Inputs to reference and feedback net
        logic divider_on;    // Common-mode divider on the supplies
    } ocs_ctrl_t;

    // Calibration memory word and its parity
    typedef struct packed {
        logic [TRIM_W-1:0] trim;
        logic              par;
    } ocs_mem_t;

endpackage

// File: rtl/ocs_top.sv
/*
 * Offset calibration sequencer: low-power select, supply-monitor
 * recovery, settle delay, offset calibration and output gating.
 * Assumes the supply monitor, select pin and comparator are
 * asynchronous to sys_clk; rst is the power-on reset.
 */
// Overview of operation
// - Select high holds low-power mode with output high impedance.
// - Select returning low starts an offset calibration sequence.
// - Sequence end drives output low impedance and resumes normal mode.
// - Each calibration runs a settle delay first, then calibrates.
// - Supply-monitor recovery and memory parity error also start calibration.
// - Pin-started calibration reaches normal operation in 5 ms.
// - During calibration output high impedance, inputs on internal network.
// - Calibration result is written into calibration memory.
// - Select pin pulled down; floating pin gives normal operation.
// - Low supply forces low-power mode whatever the select pin.
// - Supply recovery runs a delay then calibration, 200 ms total.
// - Parity checked always; error acts as power-on event, full delay.
// - Common-mode divider on the supplies only during calibration.
// - Without a select pin, calibration is launched by supply-monitor recovery or parity error only.
module ocs_top #(
    parameter bit          HAS_SELECT   = 1'b1,
    parameter int unsigned POR_DELAY    = ocs_pkg::POR_DELAY_CYC,
    parameter int unsigned SETTLE_DELAY = ocs_pkg::SETTLE_CYC,
    parameter int unsigned CAL_TIME     = ocs_pkg::CAL_CYC
) (
    input  wire logic                       sys_clk,
    input  wire logic                       rst,
    input  wire logic                       cal_select,
    input  wire logic                       supply_ok,
    input  wire logic                       offset_cmp,
    input  wire logic                       mem_upset,
    output ocs_pkg::ocs_ctrl_t              ctrl,
    output logic [ocs_pkg::TRIM_W-1:0]      trim,
    output logic                            cal_busy
);

    ////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        logic [1:0]                 sel_sync;
        logic [1:0]                 sup_sync;
        logic [1:0]                 cmp_sync;
        logic                       sel_prev;
        logic                       par_prev;
        ocs_pkg::ocs_state_t        state;
        logic [ocs_pkg::TMR_W-1:0]  tmr;
        logic [ocs_pkg::TRIM_W-1:0] acc;
        logic [ocs_pkg::TRIM_W-1:0] bit_mask;
        logic                       mem_wr;
        ocs_pkg::ocs_ctrl_t         ctrl;
    } ocs_top_state_t;

    ocs_top_state_t st_r;
    ocs_top_state_t st_nxt;

    logic                       par_err;
    logic [ocs_pkg::TRIM_W-1:0] mem_trim;
    logic                       sel_s;
    logic                       sup_s;
    logic                       cmp_s;

    // Cycle budget of the binary search steps
    localparam int unsigned STEP_CYC = CAL_TIME / ocs_pkg::TRIM_W;

    // Timer reload helper, count minus one at timer width
    function automatic logic [ocs_pkg::TMR_W-1:0] load(
        input int unsigned cyc
    );
        load = ocs_pkg::TMR_W'((cyc == 0) ? 0 : cyc - 1);
    endfunction

    // Output decode for a state
    function automatic ocs_pkg::ocs_ctrl_t ctrl_of(
        input ocs_pkg::ocs_state_t s
    );
        ctrl_of = '{out_hiz: 1'b1, low_power: 1'b1,
                    in_isolate: 1'b0, divider_on: 1'b0};
        case (s)
            ocs_pkg::OCS_NORMAL: begin
                ctrl_of = '{out_hiz: 1'b0, low_power: 1'b0,
                            in_isolate: 1'b0, divider_on: 1'b0};
            end
            ocs_pkg::OCS_SETTLE,
            ocs_pkg::OCS_CALIBRATE: begin
                ctrl_of = '{out_hiz: 1'b1, low_power: 1'b0,
                            in_isolate: 1'b1, divider_on: 1'b1};
            end
            default: begin
                ctrl_of = '{out_hiz: 1'b1, low_power: 1'b1,
                            in_isolate: 1'b0, divider_on: 1'b0};
            end
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Synchronised inputs; select absent reads as pulled low

    assign sel_s = HAS_SELECT ? st_r.sel_sync[1] : 1'b0;
    assign sup_s = st_r.sup_sync[1];
    assign cmp_s = st_r.cmp_sync[1];

    ////////////////////////////////////////////////////////////////////
    // Sequencer next state

    always_comb begin
        st_nxt          = st_r;
        st_nxt.sel_sync = {st_r.sel_sync[0], cal_select};
        st_nxt.sup_sync = {st_r.sup_sync[0], supply_ok};
        st_nxt.cmp_sync = {st_r.cmp_sync[0], offset_cmp};
        st_nxt.sel_prev = sel_s;
        st_nxt.par_prev = par_err;
        st_nxt.mem_wr   = 1'b0;
        if (st_r.tmr != '0) begin
            st_nxt.tmr = st_r.tmr - 1'b1;
        end
        // Parity error stays up until the next store, so only its onset
        // restarts; a level trigger would hold the sequencer forever
        if (!sup_s || (par_err && !st_r.par_prev)) begin
            // Low supply or fresh parity error: restart power-on delay
            st_nxt.state = ocs_pkg::OCS_POR_WAIT;
            st_nxt.tmr   = load(POR_DELAY);
        end else begin
            case (st_r.state)
                ocs_pkg::OCS_POR_WAIT: begin
                    if (st_r.tmr == '0) begin
                        // Select held high keeps low power after recovery
                        if (sel_s) begin
                            st_nxt.state = ocs_pkg::OCS_LOW_POWER;
                        end else begin
                            st_nxt.state = ocs_pkg::OCS_SETTLE;
                            st_nxt.tmr   = load(SETTLE_DELAY);
                        end
                    end
                end
                ocs_pkg::OCS_LOW_POWER: begin
                    if (!sel_s) begin
                        st_nxt.state = ocs_pkg::OCS_SETTLE;
                        st_nxt.tmr   = load(SETTLE_DELAY);
                    end
                end
                ocs_pkg::OCS_SETTLE: begin
                    if (sel_s) begin
                        st_nxt.state = ocs_pkg::OCS_LOW_POWER;
                    end else if (st_r.tmr == '0) begin
                        st_nxt.state    = ocs_pkg::OCS_CALIBRATE;
                        st_nxt.tmr      = load(STEP_CYC);
                        st_nxt.bit_mask = {1'b1, {(ocs_pkg::TRIM_W-1){1'b0}}};
                        st_nxt.acc      = {1'b1, {(ocs_pkg::TRIM_W-1){1'b0}}};
                    end
                end
                ocs_pkg::OCS_CALIBRATE: begin
                    if (sel_s) begin
                        st_nxt.state = ocs_pkg::OCS_LOW_POWER;
                    end else if (st_r.tmr == '0) begin
                        // Binary search: keep bit if offset still positive
                        st_nxt.acc = st_r.acc;
                        if (!cmp_s) begin
                            st_nxt.acc = st_r.acc & ~st_r.bit_mask;
                        end
                        st_nxt.acc = st_nxt.acc | (st_r.bit_mask >> 1);
                        st_nxt.bit_mask = st_r.bit_mask >> 1;
                        st_nxt.tmr      = load(STEP_CYC);
                        if (st_r.bit_mask[0]) begin
                            st_nxt.acc = cmp_s ? st_r.acc
                                               : st_r.acc & ~st_r.bit_mask;
                            st_nxt.mem_wr = 1'b1;
                            st_nxt.state  = ocs_pkg::OCS_NORMAL;
                        end
                    end
                end
                ocs_pkg::OCS_NORMAL: begin
                    if (sel_s) begin
                        st_nxt.state = ocs_pkg::OCS_LOW_POWER;
                    end
                end
                default: begin
                    st_nxt.state = ocs_pkg::OCS_POR_WAIT;
                    st_nxt.tmr   = load(POR_DELAY);
                end
            endcase
        end
        st_nxt.ctrl = ctrl_of(st_nxt.state);
    end

    ////////////////////////////////////////////////////////////////////
    // State register; reset behaves as a power-on event

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st_r          <= '0;
            st_r.state    <= ocs_pkg::OCS_POR_WAIT;
            st_r.tmr      <= ocs_pkg::TMR_RST;
            st_r.acc      <= ocs_pkg::TRIM_RST;
            st_r.ctrl     <= '{out_hiz: 1'b1, low_power: 1'b1,
                               in_isolate: 1'b0, divider_on: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Calibration memory

    ocs_cal_mem #(
        .W (ocs_pkg::TRIM_W)
    ) ocs_cal_mem_i (
        .sys_clk (sys_clk),
        .rst     (rst),
        .wr_en   (st_r.mem_wr),
        .wr_data (st_r.acc),
        .upset   (mem_upset),
        .trim    (mem_trim),
        .par_err (par_err)
    );

    // Outputs
    assign ctrl     = st_r.ctrl;
    assign trim     = mem_trim;
    assign cal_busy = (st_r.state == ocs_pkg::OCS_SETTLE) ||
                      (st_r.state == ocs_pkg::OCS_CALIBRATE);

    ////////////////////////////////////////////////////////////////////
    // Checks

    property p_hiz_not_normal;
        @(posedge sys_clk) disable iff (rst)
        (st_r.state != ocs_pkg::OCS_NORMAL) |-> ctrl.out_hiz;
    endproperty
    a_hiz_not_normal: assert property (p_hiz_not_normal)
        else $error("output driven outside normal operation");

    property p_sel_low_power;
        @(posedge sys_clk) disable iff (rst)
        (sel_s && sup_s && !par_err) |=> ctrl.low_power;
    endproperty
    a_sel_low_power: assert property (p_sel_low_power)
        else $error("select high without low power");

    property p_fall_starts;
        @(posedge sys_clk) disable iff (rst)
        ($fell(sel_s) && st_r.state == ocs_pkg::OCS_LOW_POWER && sup_s
         && !par_err) |=> (st_r.state == ocs_pkg::OCS_SETTLE);
    endproperty
    a_fall_starts: assert property (p_fall_starts)
        else $error("select fall did not start settle");

    property p_cal_iso;
        @(posedge sys_clk) disable iff (rst)
        cal_busy |-> (ctrl.in_isolate && ctrl.divider_on && ctrl.out_hiz);
    endproperty
    a_cal_iso: assert property (p_cal_iso)
        else $error("calibration without isolation");

    property p_div_off;
        @(posedge sys_clk) disable iff (rst)
        !cal_busy |-> !ctrl.divider_on;
    endproperty
    a_div_off: assert property (p_div_off)
        else $error("divider on outside calibration");

    property p_wr_normal;
        @(posedge sys_clk) disable iff (rst)
        st_r.mem_wr |-> (st_r.state == ocs_pkg::OCS_NORMAL && !ctrl.out_hiz);
    endproperty
    a_wr_normal: assert property (p_wr_normal)
        else $error("memory write not at end of calibration");

    property p_lowsup;
        @(posedge sys_clk) disable iff (rst)
        !sup_s |=> (st_r.state == ocs_pkg::OCS_POR_WAIT && ctrl.low_power);
    endproperty
    a_lowsup: assert property (p_lowsup)
        else $error("low supply did not force low power");

    property p_parity;
        @(posedge sys_clk) disable iff (rst)
        (par_err && !st_r.par_prev) |=> (st_r.state == ocs_pkg::OCS_POR_WAIT);
    endproperty
    a_parity: assert property (p_parity)
        else $error("parity error ignored");

    property p_settle_first;
        @(posedge sys_clk) disable iff (rst)
        (st_r.state == ocs_pkg::OCS_CALIBRATE) |->
            $past(st_r.state) inside {ocs_pkg::OCS_SETTLE,
                                      ocs_pkg::OCS_CALIBRATE};
    endproperty
    a_settle_first: assert property (p_settle_first)
        else $error("calibration without settle");

    property p_norm_drive;
        @(posedge sys_clk) disable iff (rst)
        (st_r.state == ocs_pkg::OCS_NORMAL) |->
            (!ctrl.out_hiz && !ctrl.low_power && !ctrl.in_isolate);
    endproperty
    a_norm_drive: assert property (p_norm_drive)
        else $error("normal operation without output drive");

    property p_por_sel;
        @(posedge sys_clk) disable iff (rst)
        (st_r.state == ocs_pkg::OCS_POR_WAIT && st_r.tmr == '0 && sel_s
         && sup_s && !par_err) |=> (st_r.state == ocs_pkg::OCS_LOW_POWER);
    endproperty
    a_por_sel: assert property (p_por_sel)
        else $error("supply recovery left low power with select high");

endmodule
